// ---- hw/snv_cmd.v ----
`include "snv_regs.vh"
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// special command decoder with pause support
module snv_cmd #(
	parameter [17:0] CMD_CYC = `SNV_CMD_PROC_US * `SNV_CLK_MHZ, // command processing cycles
	parameter [17:0] RESTORE_CYC = `SNV_RESTORE_US * `SNV_CLK_MHZ, // restore cycles
	parameter [17:0] SAVE_CYC = `SNV_SAVE_US * `SNV_CLK_MHZ, // save cycles
	parameter [0:0] AUTOSAVE_SUPPORTED = 1'b1 // 0 = variant with autosave fixed at its reset value (on)
) (
	input wire sys_clk, // 20 mhz block clock
	input wire arst_n, // async reset, active low
	input wire sck_pin, // serial clock from host
	input wire cs_n_pin, // chip select, active low
	input wire si_pin, // serial data in
	input wire pause_n_pin, // pause, active low
	output reg so_out, // serial output level
	output wire so_oe, // serial output enable
	output reg write_enable_latch, // write latch state
	output reg autosave_enabled, // autosave setting
	output wire ready, // high when idle, low while busy
	output reg save_pulse, // one cycle: start nonvolatile save
	output reg restore_pulse, // one cycle: start restore into sram
	output reg save_active, // save in progress
	output reg restore_active, // restore in progress
	output wire mem_access_ok // memory commands may proceed
);
	// ==========================================
	// synchronised pins
	wire sck_s, cs_n_s, si_s, pause_n_s;
	snv_sync #(.RST_VAL(1'b0)) u_sck (.sys_clk(sys_clk), .arst_n(arst_n), .d_in(sck_pin), .q_out(sck_s));
	snv_sync #(.RST_VAL(1'b1)) u_cs (.sys_clk(sys_clk), .arst_n(arst_n), .d_in(cs_n_pin), .q_out(cs_n_s));
	snv_sync #(.RST_VAL(1'b0)) u_si (.sys_clk(sys_clk), .arst_n(arst_n), .d_in(si_pin), .q_out(si_s));
	snv_sync #(.RST_VAL(1'b1)) u_ps (.sys_clk(sys_clk), .arst_n(arst_n), .d_in(pause_n_pin), .q_out(pause_n_s));

	// ==========================================
	// edge detection on synchronised levels
	reg sck_d; // previous serial clock
	reg cs_n_d; // previous chip select
	reg paused; // pause state, changes only with clock low
	reg [3:0] bit_cnt; // bits taken this frame
	reg [7:0] shreg; // code shift register
	reg [2:0] pend; // code awaiting chip select rise
	reg [17:0] busy_cnt; // busy interval countdown
	wire sck_rise = sck_s & ~sck_d;
	wire cs_rise = cs_n_s & ~cs_n_d;
	wire cs_fall = ~cs_n_s & cs_n_d;
	wire busy = (busy_cnt != 18'h0);

	localparam [2:0] P_NONE = 3'h0;
	localparam [2:0] P_SAVE = 3'h1;
	localparam [2:0] P_RESTORE = 3'h2;
	localparam [2:0] P_AS_ON = 3'h3;
	localparam [2:0] P_AS_OFF = 3'h4;
	localparam [2:0] P_SETL = 3'h5;
	localparam [2:0] P_CLRL = 3'h6;

	assign ready = ~busy;
	assign mem_access_ok = ~busy & ~save_active & ~restore_active;
	// released while paused or deselected
	assign so_oe = ~cs_n_s & ~paused;

	// decoded code from completed byte
	reg [2:0] dec;
	always @* begin
		case (shreg)
			`SNV_CMD_SAVE: dec = P_SAVE;
			`SNV_CMD_RESTORE: dec = P_RESTORE;
			`SNV_CMD_AUTOSAVE_ON: dec = P_AS_ON;
			`SNV_CMD_AUTOSAVE_OFF: dec = P_AS_OFF;
			`SNV_CMD_SET_LATCH: dec = P_SETL;
			`SNV_CMD_CLR_LATCH: dec = P_CLRL;
			default: dec = P_NONE;
		endcase
	end

	// ==========================================
	// serial front end: pause, shift, frame
	// pause state is sampled only while sck is low, so a glitch at high clock cannot enter it
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sck_d <= 1'b0;
			cs_n_d <= 1'b1;
			paused <= 1'b0;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			pend <= P_NONE;
		end else begin
			sck_d <= sck_s;
			cs_n_d <= cs_n_s;
			if (!sck_s && (!cs_n_s || paused))
				paused <= ~pause_n_s;
			if (cs_fall && !paused) begin
				// new frame; a paused one resumes instead
				bit_cnt <= 4'h0;
				pend <= P_NONE;
			end else if (!cs_n_s && !paused && sck_rise && bit_cnt < 4'h8) begin
				// bits past the code do not shift, so the counter cannot wrap
				shreg <= {shreg[6:0], si_s};
				bit_cnt <= bit_cnt + 4'h1;
			end else if (bit_cnt == 4'h8 && pend == P_NONE && !cs_n_s) begin
				pend <= dec;
				bit_cnt <= 4'h9; // extra bits ignored
			end
			if (cs_rise && !paused) begin
				pend <= P_NONE;
				bit_cnt <= 4'h0;
			end
		end
	end

	// ==========================================
	// command execution at closing chip select rise
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			write_enable_latch <= `SNV_LATCH_RST;
			autosave_enabled <= `SNV_AUTOSAVE_RST;
			busy_cnt <= 18'h0;
			save_pulse <= 1'b0;
			restore_pulse <= 1'b0;
			save_active <= 1'b0;
			restore_active <= 1'b0;
			so_out <= 1'b0;
		end else begin
			save_pulse <= 1'b0;
			restore_pulse <= 1'b0;
			so_out <= 1'b0;
			if (busy)
				busy_cnt <= busy_cnt - 18'h1;
			else begin
				save_active <= 1'b0;
				restore_active <= 1'b0;
			end
			if (cs_rise && !paused && !busy) begin
				case (pend)
					P_SETL: write_enable_latch <= 1'b1;
					P_CLRL: write_enable_latch <= 1'b0;
					P_SAVE: if (write_enable_latch) begin
						save_pulse <= 1'b1;
						save_active <= 1'b1;
						busy_cnt <= SAVE_CYC;
						write_enable_latch <= 1'b0;
					end
					P_RESTORE: if (write_enable_latch) begin
						restore_pulse <= 1'b1;
						restore_active <= 1'b1;
						busy_cnt <= RESTORE_CYC;
						write_enable_latch <= 1'b0;
					end
					P_AS_ON, P_AS_OFF: if (write_enable_latch) begin
						if (AUTOSAVE_SUPPORTED)
							autosave_enabled <= (pend == P_AS_ON);
						busy_cnt <= CMD_CYC;
						write_enable_latch <= 1'b0;
					end
					// unknown code or short frame: command dropped, wait for next frame
					default: ;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ---- hw/snv_regs.vh ----
// Operation
// - save code 3c, restore code 60
// - autosave on 59, off 19
// - save always runs, dirty or not
// - special commands need write latch set
// - code follows chip select falling edge
// - latch clears at closing chip select rise
// - restore copies nonvolatile into sram
// - autosave enabled by default where supported
// - autosave setting volatile, kept by save
// - no-autosave variant: setting fixed, still busy
// - pause acts only while selected, mid-sequence
// - paused: input ignored, output released, frozen
// - deselect during pause, resume sequence later
// - latch clear: ignore, wait new frame
// - command 100 us, restore 200 us max
// - save 8 ms max; memory locked out
`ifndef SNV_REGS_VH
`define SNV_REGS_VH
// ==========================================
// command codes
`define SNV_CMD_SAVE 8'h3c
`define SNV_CMD_RESTORE 8'h60
`define SNV_CMD_AUTOSAVE_ON 8'h59
`define SNV_CMD_AUTOSAVE_OFF 8'h19
`define SNV_CMD_SET_LATCH 8'h06
`define SNV_CMD_CLR_LATCH 8'h04
// ==========================================
// timing, in microseconds, and clock rate
`define SNV_CLK_MHZ 20
`define SNV_CMD_PROC_US 100
`define SNV_RESTORE_US 200
`define SNV_SAVE_US 8000
// ==========================================
// reset values
`define SNV_AUTOSAVE_RST 1'b1
`define SNV_LATCH_RST 1'b0
`endif

// ---- hw/snv_sync.v ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// two flop synchroniser for pin inputs
module snv_sync #(
	parameter [0:0] RST_VAL = 1'b1 // idle level of the pin, held during reset
) (
	input wire sys_clk, // block clock
	input wire arst_n, // async reset, active low
	input wire d_in, // asynchronous pin
	output reg q_out // synchronised level
);
	reg meta; // first stage, read only by q_out

	// reset to the pin's idle level so no false edge follows reset
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta <= RST_VAL;
			q_out <= RST_VAL;
		end else begin
			meta <= d_in;
			q_out <= meta;
		end
	end
endmodule
`default_nettype wire

// ---- verif/snv_cmd_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checks of the command decoder
module snv_chk (
	input wire logic sys_clk, // clock
	input wire logic arst_n, // reset
	input wire logic cs_n_pin, // select
	input wire logic write_enable_latch, // latch
	input wire logic autosave_enabled, // setting
	input wire logic ready, // idle
	input wire logic save_pulse, // save start
	input wire logic restore_pulse, // restore start
	input wire logic save_active, // saving
	input wire logic restore_active, // restoring
	input wire logic mem_access_ok, // access allowed
	input wire logic so_oe // output driven
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// busy as seen by a memory command
	sequence busy_s;
		!ready && !mem_access_ok;
	endsequence
	save_busy_a: assert property (save_pulse |=> save_active ##0 busy_s) else $error("save idle");
	rest_busy_a: assert property (restore_pulse |=> restore_active ##0 busy_s) else $error("rest idle");
	latch_clear_a: assert property ((save_pulse || restore_pulse) |=> !write_enable_latch) else $error("latch");
	at_cs_rise_a: assert property ((save_pulse || restore_pulse) |-> cs_n_pin) else $error("early");
	one_start_a: assert property (save_pulse |=> !save_pulse && !restore_pulse) else $error("pulse");
	mem_lock_a: assert property ((save_active || restore_active) |-> !mem_access_ok) else $error("lock");
	busy_lock_a: assert property (!ready |-> !mem_access_ok) else $error("busy");
	set_frame_a: assert property ($changed(autosave_enabled) |-> cs_n_pin) else $error("setting");
	idle_release_a: assert property ((cs_n_pin && $past(cs_n_pin) && $past(cs_n_pin, 2)) |-> !so_oe) else $error("oe");
endmodule
bind snv_cmd snv_chk u_chk (.*);
`default_nettype wire

// ---- verif/snv_cmd_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module snv_cmd_tb;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic sck, cs_n, si, pause_n, wel, ase, rdy, sp, rp;
	int n_fail = 0, n_checks = 0, n_sv = 0, n_rs = 0;
	always #25 sys_clk = ~sys_clk;
	// pulses last one cycle, so count them
	always @(posedge sys_clk) begin
		n_sv <= n_sv + int'(sp === 1'b1);
		n_rs <= n_rs + int'(rp === 1'b1);
	end
	snv_host h (.sys_clk(sys_clk), .sck(sck), .cs_n(cs_n), .si(si), .pause_n(pause_n));
	snv_cmd #(.CMD_CYC(18'h14), .RESTORE_CYC(18'h28), .SAVE_CYC(18'h3c)) dut (.sys_clk(sys_clk),
		.arst_n(arst_n), .sck_pin(sck), .cs_n_pin(cs_n), .si_pin(si), .pause_n_pin(pause_n),
		.so_out(), .so_oe(), .write_enable_latch(wel), .autosave_enabled(ase), .ready(rdy),
		.save_pulse(sp), .restore_pulse(rp), .save_active(), .restore_active(), .mem_access_ok());
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// frames ended while busy are dropped, so wait it out
	task automatic idle;
		int i;
		repeat (8) @(posedge sys_clk);
		for (i = 0; i < 300 && rdy !== 1'b1; i++) @(posedge sys_clk);
		if (i == 300) begin
			n_fail++;
			report_and_stop;
		end
	endtask
	task automatic cmd(input logic [7:0] c, input int hp);
		h.frame(8'h06, -1);
		idle;
		chk("latch", 8'h01, {7'h0, wel});
		h.frame(c, hp);
		idle;
		chk("latch", 8'h00, {7'h0, wel});
	endtask
	task automatic t_auto;
		chk("auto", 8'h01, {7'h0, ase});
		cmd(8'h19, -1);
		chk("auto", 8'h00, {7'h0, ase});
		cmd(8'h59, 6);
		chk("auto", 8'h01, {7'h0, ase});
		$display("t_auto end");
	endtask
	task automatic t_save;
		int s = n_sv;
		cmd(8'h3c, -1);
		chk("save", 8'(s + 1), 8'(n_sv));
		$display("t_save end");
	endtask
	task automatic t_rest;
		int r = n_rs;
		cmd(8'h60, 3);
		chk("rest", 8'(r + 1), 8'(n_rs));
		$display("t_rest end");
	endtask
	task automatic t_nolatch;
		int s = n_sv;
		h.frame(8'h3c, -1);
		idle;
		chk("save", 8'(s), 8'(n_sv));
		$display("t_nolatch end");
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		#1 arst_n = 1'b1;
		t_auto;
		t_save;
		t_rest;
		t_nolatch;
		report_and_stop;
	end
endmodule
`default_nettype wire

// ---- verif/snv_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// spi host, mode 0, clock rests low
module snv_host (
	input wire logic sys_clk, // bench clock
	output var logic sck, // serial clock
	output var logic cs_n, // select
	output var logic si, // data
	output var logic pause_n // pause
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		pause_n = 1'b1;
	end
	// one code msb first; pause after bit hp
	task automatic frame(input logic [7:0] c, input int hp);
		@(posedge sys_clk) #1 cs_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			si = c[i];
			#200 sck = 1'b1;
			#200 sck = 1'b0;
			if (i == hp) begin
				pause_n = 1'b0;
				repeat (2) begin
					si = ~si;
					#200 sck = 1'b1;
					#200 sck = 1'b0;
				end
				cs_n = 1'b1;
				#400 cs_n = 1'b0;
				#200 pause_n = 1'b1;
			end
		end
		#200 cs_n = 1'b1;
		si = ~si; // line not held after frame
	endtask
endmodule
`default_nettype wire
